// ---- core/xbc_bus_ctrl.sv ----
// Contract
// - Area access: three states if bit set
// - Area 4 wait field gives wait cycles
// - SDRAM: area 2 field low bits latency
// - Nonzero idle field inserts idle cycle
// - Endian bit zero means big endian
// - Byte-control SRAM interface when bit set; area 2 never gets it while DRAM is selected
// - Area 2 becomes DRAM when selected
// - Type bit set means SDRAM
// - Output-enable bit drives OE or CKE
// - Burst bit enables page-mode bursts
// - Precharge field sets cycles, 00 one
// - RAS-to-CAS field inserts wait cycles
// - Mode register programming only when enabled
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "xbc_defines.svh"

module xbc_bus_ctrl (
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic [25:0]        avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic      [31:0]        avs_readdata,
    output logic                    avs_waitrequest,
    input  wire logic               acc_valid,
    input  wire xbc_pkg::xbc_acc_t  acc_req,
    output logic                    acc_ack,
    output logic      [15:0]        acc_rdata,
    output xbc_pkg::xbc_ext_t       ext_ctrl,
    input  wire logic [15:0]        ext_data_in,
    output logic      [15:0]        ext_data_out,
    output logic                    ext_data_oe_n
);
    import xbc_pkg::*;

    logic [15:0] regs_reg [`XBC_NUM_REGS];
    logic        wait_reg;
    logic [31:0] rdata_reg;
    logic        hit;
    logic [3:0]  slot;
    logic [15:0] wr_masked;

    xbc_state_t  state_reg, state_next;
    logic [2:0]  cnt_reg, cnt_next;
    xbc_acc_t    req_reg, req_next;
    logic        page_open_reg, page_open_next;
    logic        reopen_reg, reopen_next;
    logic        take, done, cap;
    logic        ack_reg;
    logic [15:0] acc_rdata_reg, ext_wdata_reg;
    xbc_ext_t    ext_reg, ext_next;
    logic        oe_n_reg;

    function automatic logic [4:0] decode(input logic [23:0] idx);
        case (idx)
            `XBC_IDX_AREA_ACCESS_STATE: decode = {1'b1, `XBC_R_AST};
            `XBC_IDX_AREA4_WAIT:        decode = {1'b1, `XBC_R_W4};
            `XBC_IDX_AREA2_WAIT:        decode = {1'b1, `XBC_R_W2};
            `XBC_IDX_IDLE_CYCLE:        decode = {1'b1, `XBC_R_IDLE};
            `XBC_IDX_AREA_ENDIAN:       decode = {1'b1, `XBC_R_END};
            `XBC_IDX_SRAM_MODE:         decode = {1'b1, `XBC_R_SRAM};
            `XBC_IDX_DRAM_IF:           decode = {1'b1, `XBC_R_DRAM};
            `XBC_IDX_DRAM_TIMING:       decode = {1'b1, `XBC_R_TIM};
            `XBC_IDX_SYNC_DRAM:         decode = {1'b1, `XBC_R_SD};
            default:                    decode = 5'h00;
        endcase
    endfunction

    function automatic logic [15:0] reg_mask(input logic [3:0] s);
        case (s)
            `XBC_R_AST:  reg_mask = `XBC_MASK_AST;
            `XBC_R_W4:   reg_mask = `XBC_MASK_W4;
            `XBC_R_W2:   reg_mask = `XBC_MASK_W2;
            `XBC_R_IDLE: reg_mask = `XBC_MASK_IDLE;
            `XBC_R_END:  reg_mask = `XBC_MASK_END;
            `XBC_R_SRAM: reg_mask = `XBC_MASK_SRAM;
            `XBC_R_DRAM: reg_mask = `XBC_MASK_DRAM;
            `XBC_R_TIM:  reg_mask = `XBC_MASK_TIM;
            `XBC_R_SD:   reg_mask = `XBC_MASK_SD;
            default:     reg_mask = 16'h0000;
        endcase
    endfunction

    // Byte swap for little-endian areas; big endian passes straight
    function automatic logic [15:0] order(input logic [15:0] d,
                                          input logic        le);
        order = le ? {d[7:0], d[15:8]} : d;
    endfunction

    assign {hit, slot} = decode(avs_address[25:2]);
    assign wr_masked   = avs_writedata[15:0] & reg_mask(slot);

    // Avalon slave: one wait cycle, then answer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg <= 1'b1;
        end else if ((avs_read || avs_write) && wait_reg) begin
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (avs_read && wait_reg) begin
            rdata_reg <= hit ? {16'h0000, regs_reg[slot]} : 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `XBC_NUM_REGS; i++) begin
                regs_reg[i] <= `XBC_RESET_VAL;
            end
        end else if (avs_write && !wait_reg && hit) begin
            if (avs_byteenable[0]) begin
                regs_reg[slot][7:0] <= wr_masked[7:0];
            end
            if (avs_byteenable[1]) begin
                regs_reg[slot][15:8] <= wr_masked[15:8];
            end
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata    = rdata_reg;

    // Configuration fields
    logic       area4_three_state_sel, area2_three_state_sel, le4, le2, bc4, bc2;
    logic       dram_sel, kind_sdram, oe_cke_output_en, burst_en, mode_reg_program_en;
    logic [2:0] w4, w2;
    logic [1:0] cl_code, tpc, rcd;
    logic       idle_on;

    assign area4_three_state_sel       = regs_reg[`XBC_R_AST][`XBC_B_AREA4_THREE_STATE_SEL];
    assign area2_three_state_sel       = regs_reg[`XBC_R_AST][`XBC_B_AREA2_THREE_STATE_SEL];
    assign w4         = regs_reg[`XBC_R_W4][`XBC_F_W4];
    assign w2         = regs_reg[`XBC_R_W2][`XBC_F_W2];
    assign cl_code    = regs_reg[`XBC_R_W2][`XBC_F_W2_CL];
    assign idle_on    = |regs_reg[`XBC_R_IDLE][`XBC_F_IDLE];
    assign le4        = regs_reg[`XBC_R_END][`XBC_B_LE4];
    assign le2        = regs_reg[`XBC_R_END][`XBC_B_LE2];
    assign bc4        = regs_reg[`XBC_R_SRAM][`XBC_B_AREA4_BYTE_CTRL_SRAM_SEL];
    assign bc2        = regs_reg[`XBC_R_SRAM][`XBC_B_AREA2_BYTE_CTRL_SRAM_SEL];
    assign dram_sel   = regs_reg[`XBC_R_DRAM][`XBC_B_DRAM_SEL];
    assign kind_sdram = regs_reg[`XBC_R_DRAM][`XBC_B_KIND];
    assign oe_cke_output_en        = regs_reg[`XBC_R_DRAM][`XBC_B_OEE];
    assign burst_en   = regs_reg[`XBC_R_DRAM][`XBC_B_BURST];
    assign tpc        = regs_reg[`XBC_R_TIM][`XBC_F_TPC];
    assign rcd        = regs_reg[`XBC_R_TIM][`XBC_F_RCD];
    assign mode_reg_program_en       = regs_reg[`XBC_R_SD][`XBC_B_MODE_REG_PROGRAM_EN];

    // Per-request view of the current area
    logic       cur_dram, cur_sdram, cur_ast;
    logic [2:0] cur_waits;
    assign cur_dram  = !req_reg.area4 && dram_sel;
    assign cur_sdram = cur_dram && kind_sdram;
    assign cur_ast   = req_reg.area4 ? area4_three_state_sel : area2_three_state_sel;
    // Plain area 2 uses its full wait field; area 4 its own
    assign cur_waits = req_reg.area4 ? w4 : w2;

    function automatic xbc_state_t entry(input logic a4,
                                         input logic open);
        if (a4 || !dram_sel) begin
            entry = ST_T1;
        end else if (open && burst_en) begin
            entry = ST_CAS;
        end else begin
            entry = ST_RAS;
        end
    endfunction

    always_comb begin
        state_next     = state_reg;
        cnt_next       = cnt_reg;
        page_open_next = page_open_reg;
        reopen_next    = reopen_reg;
        take           = 1'b0;
        done           = 1'b0;
        cap            = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (acc_valid && !ack_reg) begin
                    take = 1'b1;
                    // Open page must close unless this continues it
                    if (page_open_reg && (acc_req.area4 || !dram_sel
                                          || !burst_en)) begin
                        state_next     = ST_PRE;
                        cnt_next       = {1'b0, tpc};
                        page_open_next = 1'b0;
                        reopen_next    = 1'b1;
                    end else begin
                        state_next = entry(acc_req.area4, page_open_reg);
                    end
                end
            end
            ST_T1: state_next = ST_T2;
            ST_T2: begin
                if (!cur_ast) begin
                    cap  = 1'b1;
                    done = 1'b1;
                end else if (cur_waits != 3'h0) begin
                    state_next = ST_WAIT;
                    cnt_next   = cur_waits - 3'h1;
                end else begin
                    state_next = ST_T3;
                end
            end
            ST_WAIT: begin
                if (cnt_reg == 3'h0) begin
                    state_next = ST_T3;
                end else begin
                    cnt_next = cnt_reg - 3'h1;
                end
            end
            ST_T3: begin
                cap  = 1'b1;
                done = 1'b1;
            end
            ST_RAS: begin
                if (rcd != 2'h0) begin
                    state_next = ST_RCD;
                    cnt_next   = {1'b0, rcd - 2'h1};
                end else begin
                    state_next = ST_CAS;
                end
            end
            ST_RCD: begin
                if (cnt_reg == 3'h0) begin
                    state_next = ST_CAS;
                end else begin
                    cnt_next = cnt_reg - 3'h1;
                end
            end
            ST_CAS, ST_CL: begin
                if (state_reg == ST_CAS && cur_sdram && !req_reg.write
                    && cl_code != 2'h0) begin
                    state_next = ST_CL;
                    cnt_next   = {1'b0, cl_code - 2'h1};
                end else if (state_reg == ST_CL && cnt_reg != 3'h0) begin
                    cnt_next = cnt_reg - 3'h1;
                end else begin
                    cap = 1'b1;
                    if (burst_en && req_reg.burst_more) begin
                        page_open_next = 1'b1;
                        done           = 1'b1;
                    end else begin
                        page_open_next = 1'b0;
                        reopen_next    = 1'b0;
                        state_next     = ST_PRE;
                        cnt_next       = {1'b0, tpc};
                    end
                end
            end
            ST_PRE: begin
                if (cnt_reg != 3'h0) begin
                    cnt_next = cnt_reg - 3'h1;
                end else if (reopen_reg) begin
                    reopen_next = 1'b0;
                    state_next  = entry(req_reg.area4, 1'b0);
                end else begin
                    done = 1'b1;
                end
            end
            ST_GAP:  state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
        if (done) begin
            state_next = idle_on ? ST_GAP : ST_IDLE;
        end
    end

    assign req_next = take ? acc_req : req_reg;

    always_comb begin
        logic act, dr, sd, cas_ph;
        act    = state_next inside {ST_T1, ST_T2, ST_WAIT, ST_T3,
                                    ST_RAS, ST_RCD, ST_CAS, ST_CL};
        dr     = !req_next.area4 && dram_sel;
        sd     = dr && kind_sdram;
        cas_ph = state_next inside {ST_CAS, ST_CL};
        ext_next.cs   = act;
        ext_next.ras  = state_next inside {ST_RAS, ST_RCD, ST_CAS, ST_CL};
        ext_next.cas  = cas_ph;
        // Mode register set replaces a byte-only SDRAM write when enabled
        ext_next.mrs  = state_next == ST_CAS && sd && mode_reg_program_en
                        && req_next.write && req_next.byte_only;
        ext_next.wr   = act && req_next.write && !ext_next.mrs;
        ext_next.oe   = oe_cke_output_en && dr && !kind_sdram && cas_ph
                        && !req_next.write;
        ext_next.cke  = oe_cke_output_en && dram_sel && kind_sdram;
        // Byte control is masked off while area 2 is DRAM, whatever bc2 holds
        ext_next.byte_ctrl = act && !dr
                             && (req_next.area4 ? bc4 : bc2);
        ext_next.idle = state_next == ST_GAP;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= ST_IDLE;
            cnt_reg       <= 3'h0;
            page_open_reg <= 1'b0;
            reopen_reg    <= 1'b0;
            req_reg       <= '0;
        end else begin
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            page_open_reg <= page_open_next;
            reopen_reg    <= reopen_next;
            req_reg       <= req_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg       <= 1'b0;
            acc_rdata_reg <= 16'h0000;
            ext_wdata_reg <= 16'h0000;
            ext_reg       <= '0;
            oe_n_reg      <= 1'b1;
        end else begin
            ack_reg  <= done;
            ext_reg  <= ext_next;
            oe_n_reg <= !(ext_next.wr || ext_next.mrs);
            if (take) begin
                ext_wdata_reg <= order(acc_req.wdata, acc_req.area4 ? le4
                                                                : le2);
            end
            if (cap && !req_reg.write) begin
                acc_rdata_reg <= order(ext_data_in, req_reg.area4 ? le4
                                                              : le2);
            end
        end
    end

    assign acc_ack       = ack_reg;
    assign acc_rdata     = acc_rdata_reg;
    assign ext_ctrl      = ext_reg;
    assign ext_data_out  = ext_wdata_reg;
    assign ext_data_oe_n = oe_n_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_two_state_end: assert property (
        state_reg == ST_T2 && !cur_ast |=> state_reg inside {ST_IDLE, ST_GAP}
    ) else $error("Two-state access ran past T2");
    chk_three_state_end: assert property (
        state_reg == ST_T2 && cur_ast && cur_waits == 3'h0 |=> state_reg == ST_T3
    ) else $error("Three-state access skipped T3");
    chk_area4_wait7: assert property (
        state_reg == ST_T2 && cur_ast && req_reg.area4 && w4 == 3'h7
        |=> (state_reg == ST_WAIT)[*7] ##1 state_reg == ST_T3
    ) else $error("Area 4 code 7 did not give seven waits");
    chk_cas_latency2: assert property (
        state_reg == ST_CAS && cur_sdram && !req_reg.write && cl_code == 2'h1
        |=> state_reg == ST_CL ##1 state_reg != ST_CL
    ) else $error("CAS latency code 01 not two cycles");
    chk_idle_gap: assert property (
        done && idle_on |=> ext_ctrl.idle && acc_ack ##1 !ext_ctrl.idle
    ) else $error("Idle cycle missing after bus cycle");
    chk_no_idle_gap: assert property (
        done && !idle_on |=> !ext_ctrl.idle
    ) else $error("Idle cycle inserted with zero field");
    chk_endian_big: assert property (
        take && !acc_req.area4 && !le2 |=> ext_data_out == $past(acc_req.wdata)
    ) else $error("Big-endian data reordered");
    chk_byte_ctrl_sel: assert property (
        ext_ctrl.cs && !cur_dram && !ext_ctrl.byte_ctrl
        |-> !(req_reg.area4 ? bc4 : bc2)
    ) else $error("Byte-control interface not used");
    chk_dram_entry: assert property (
        take && !acc_req.area4 && dram_sel && !page_open_reg
        |=> state_reg == ST_RAS && ext_ctrl.ras
    ) else $error("DRAM access did not start with RAS");
    chk_cke_level: assert property (
        ##1 (oe_cke_output_en && dram_sel && kind_sdram) |=> ext_ctrl.cke
    ) else $error("CKE not driven for SDRAM");
    chk_precharge_one: assert property (
        state_next == ST_PRE && state_reg != ST_PRE && tpc == 2'h0
        |=> state_reg == ST_PRE ##1 state_reg != ST_PRE
    ) else $error("Precharge code 00 not one cycle");
    chk_rcd_none: assert property (
        state_reg == ST_RAS && rcd == 2'h0 |=> state_reg == ST_CAS
    ) else $error("RAS-to-CAS wait inserted with code 00");
    chk_mrs_block: assert property (
        ext_ctrl.mrs |-> $past(mode_reg_program_en)
    ) else $error("Mode register set while disabled");
    chk_burst_off: assert property (
        state_reg == ST_CAS && state_next != ST_CL && !burst_en
        |=> state_reg == ST_PRE
    ) else $error("Page kept open with burst disabled");

    cov_burst_hit: cover property (take && page_open_reg && burst_en);
    cov_mrs_cmd:   cover property (ext_ctrl.mrs);
    cov_wait7:     cover property (state_reg == ST_WAIT && w4 == 3'h7);
    cov_idle_gap:  cover property (ext_ctrl.idle);

endmodule
`default_nettype wire

// ---- core/xbc_defines.svh ----
`ifndef XBC_DEFINES_SVH
`define XBC_DEFINES_SVH

// Register index; byte address = 4 * index
`define XBC_IDX_AREA_ACCESS_STATE  24'hfffd86
`define XBC_IDX_AREA4_WAIT         24'hfffd88
`define XBC_IDX_AREA2_WAIT         24'hfffd8a
`define XBC_IDX_IDLE_CYCLE         24'hfffd90
`define XBC_IDX_AREA_ENDIAN        24'hfffd95
`define XBC_IDX_SRAM_MODE          24'hfffd98
`define XBC_IDX_DRAM_IF            24'hfffda0
`define XBC_IDX_DRAM_TIMING        24'hfffda2
`define XBC_IDX_SYNC_DRAM          24'hfffda4

// Slot in the register array
`define XBC_NUM_REGS  9
`define XBC_R_AST     4'h0
`define XBC_R_W4      4'h1
`define XBC_R_W2      4'h2
`define XBC_R_IDLE    4'h3
`define XBC_R_END     4'h4
`define XBC_R_SRAM    4'h5
`define XBC_R_DRAM    4'h6
`define XBC_R_TIM     4'h7
`define XBC_R_SD      4'h8

// Implemented bits; all others read zero
`define XBC_MASK_AST   16'h1400
`define XBC_MASK_W4    16'h0007
`define XBC_MASK_W2    16'h0700
`define XBC_MASK_IDLE  16'hf000
`define XBC_MASK_END   16'h0014
`define XBC_MASK_SRAM  16'h1400
`define XBC_MASK_DRAM  16'hc880
`define XBC_MASK_TIM   16'h3300
`define XBC_MASK_SD    16'h8000
`define XBC_RESET_VAL  16'h0000

// Field positions
`define XBC_B_AREA4_THREE_STATE_SEL      12
`define XBC_B_AREA2_THREE_STATE_SEL      10
`define XBC_F_W4        2:0
`define XBC_F_W2        10:8
`define XBC_F_W2_CL     9:8
`define XBC_F_IDLE      15:12
`define XBC_B_LE4       4
`define XBC_B_LE2       2
`define XBC_B_AREA4_BYTE_CTRL_SRAM_SEL    12
`define XBC_B_AREA2_BYTE_CTRL_SRAM_SEL    10
`define XBC_B_DRAM_SEL  15
`define XBC_B_KIND      14
`define XBC_B_OEE       11
`define XBC_B_BURST     7
`define XBC_F_TPC       13:12
`define XBC_F_RCD       9:8
`define XBC_B_MODE_REG_PROGRAM_EN      15

`endif

// ---- core/xbc_pkg.sv ----
package xbc_pkg;

    typedef enum logic [3:0] {
        ST_IDLE, ST_T1, ST_T2, ST_WAIT, ST_T3,
        ST_RAS, ST_RCD, ST_CAS, ST_CL, ST_PRE, ST_GAP
    } xbc_state_t;

    // Access request from the internal bus side
    typedef struct packed {
        logic        area4;
        logic        write;
        logic        byte_only;
        logic        burst_more;
        logic [15:0] wdata;
    } xbc_acc_t;

    // External memory strobes, all active high
    typedef struct packed {
        logic cs;
        logic ras;
        logic cas;
        logic wr;
        logic oe;
        logic cke;
        logic mrs;
        logic byte_ctrl;
        logic idle;
    } xbc_ext_t;

endpackage

// ---- tb/tb_xbc_bus_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "xbc_defines.svh"
module tb_xbc_bus_ctrl;
    import xbc_pkg::*;
    typedef struct {
        logic [15:0] ast, w4, w2, le, bcs;
        logic        a4, wr;
        int          cyc;
        logic [15:0] dat;
        logic        bc;
    } xbc_row_t;
    logic        ref_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
    logic        acc_valid = 0, avs_waitrequest, acc_ack, ext_data_oe_n;
    logic [25:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, rd;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [15:0] acc_rdata, ext_data_in, ext_data_out, wd_seen;
    xbc_acc_t    acc_req = '0;
    xbc_ext_t    ext_ctrl;
    int          fails = 0, compares = 0, n0, n1, t0, t1, t2, t3;
    int          n_ras = 0, n_oe = 0, n_idle = 0, n_mrs = 0, n_bc = 0;
    logic [23:0] idx_l [9] = '{`XBC_IDX_AREA_ACCESS_STATE,
        `XBC_IDX_AREA4_WAIT, `XBC_IDX_AREA2_WAIT, `XBC_IDX_IDLE_CYCLE,
        `XBC_IDX_AREA_ENDIAN, `XBC_IDX_SRAM_MODE, `XBC_IDX_DRAM_IF,
        `XBC_IDX_DRAM_TIMING, `XBC_IDX_SYNC_DRAM};
    logic [15:0] msk_l [9] = '{`XBC_MASK_AST, `XBC_MASK_W4, `XBC_MASK_W2,
        `XBC_MASK_IDLE, `XBC_MASK_END, `XBC_MASK_SRAM, `XBC_MASK_DRAM,
        `XBC_MASK_TIM, `XBC_MASK_SD};
    xbc_row_t    rows [5] = '{
        '{16'h0000, 16'h0, 16'h0000, 16'h0000, 16'h0000, 1, 1, 4, 16'h12c4, 0},
        '{16'h1000, 16'h0, 16'h0000, 16'h0010, 16'h0000, 1, 1, 5, 16'hc412, 0},
        '{16'h1000, 16'h7, 16'h0000, 16'h0000, 16'h1000, 1, 0, 12, 16'h12c4, 1},
        '{16'h0400, 16'h0, 16'h0500, 16'h0004, 16'h0000, 0, 0, 10, 16'hc412, 0},
        '{16'h0000, 16'h7, 16'h0000, 16'h0000, 16'h0400, 0, 1, 4, 16'h12c4, 1}};
    xbc_bus_ctrl DUT (.ref_clk(ref_clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .acc_valid(acc_valid),
        .acc_req(acc_req), .acc_ack(acc_ack), .acc_rdata(acc_rdata),
        .ext_ctrl(ext_ctrl), .ext_data_in(ext_data_in),
        .ext_data_out(ext_data_out), .ext_data_oe_n(ext_data_oe_n));
    xbc_mem_model MEM (.ref_clk(ref_clk), .rst_n(rst_n),
        .ext_ctrl(ext_ctrl), .ext_data_oe_n(ext_data_oe_n),
        .ext_data_in(ext_data_in));
    always #2.5 ref_clk = ~ref_clk;
    // Non-blocking so readers at the same edge see a settled count
    always @(posedge ref_clk) begin
        if (ext_ctrl.ras) n_ras <= n_ras + 1;
        if (ext_ctrl.oe) n_oe <= n_oe + 1;
        if (ext_ctrl.idle) n_idle <= n_idle + 1;
        if (ext_ctrl.mrs) n_mrs <= n_mrs + 1;
        if (ext_ctrl.byte_ctrl) n_bc <= n_bc + 1;
        if (ext_ctrl.wr) wd_seen <= ext_data_out;
    end
    task automatic check(input string nm, input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic finish_test;
        if (fails == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [23:0] idx,
                       input logic [15:0] wd);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {16'h0000, wd};
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // Next call must not reassign a strobe in this time step
        @(posedge ref_clk);
    endtask
    task automatic wrr(input logic [23:0] idx, input logic [15:0] v);
        bus(1'b1, idx, v);
    endtask
    // Cycles from raising valid to the edge that samples the ack
    task automatic acc(input logic a4, wr, bo, bm, output int cyc);
        acc_valid <= 1'b1;
        acc_req <= '{a4, wr, bo, bm, 16'h12c4};
        cyc = 0;
        do begin
            @(posedge ref_clk);
            cyc++;
        end while (acc_ack !== 1'b1);
        acc_valid <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    initial begin
        #400000;
        fails++;
        finish_test();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        check("waitreq_rst", avs_waitrequest, 1);
        check("oe_n_rst", ext_data_oe_n, 1);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        foreach (idx_l[i]) begin
            bus(1'b0, idx_l[i], 16'h0);
            check("reset_val", rd, 0);
            wrr(idx_l[i], 16'hffff);
            bus(1'b0, idx_l[i], 16'h0);
            check("rw_mask", rd, {16'h0000, msk_l[i]});
            wrr(idx_l[i], 16'h0000);
        end
        wrr(24'hfffd84, 16'hffff);
        bus(1'b0, 24'hfffd84, 16'h0);
        check("unmapped", rd, 0);
        foreach (rows[i]) begin
            wrr(`XBC_IDX_AREA_ACCESS_STATE, rows[i].ast);
            wrr(`XBC_IDX_AREA4_WAIT, rows[i].w4);
            wrr(`XBC_IDX_AREA2_WAIT, rows[i].w2);
            wrr(`XBC_IDX_AREA_ENDIAN, rows[i].le);
            wrr(`XBC_IDX_SRAM_MODE, rows[i].bcs);
            n0 = n_bc;
            acc(rows[i].a4, rows[i].wr, 1'b0, 1'b0, t0);
            check("cycles", t0, rows[i].cyc);
            check("data", rows[i].wr ? wd_seen : acc_rdata,
                  rows[i].dat);
            check("byte_ctrl", n_bc > n0, rows[i].bc);
        end
        wrr(`XBC_IDX_SRAM_MODE, 16'h0000);
        wrr(`XBC_IDX_AREA_ACCESS_STATE, 16'h0000);
        wrr(`XBC_IDX_IDLE_CYCLE, 16'h8000);
        n0 = n_idle;
        acc(1'b1, 1'b1, 1'b0, 1'b0, t0);
        check("idle_on", n_idle - n0, 1);
        wrr(`XBC_IDX_IDLE_CYCLE, 16'h0000);
        n0 = n_idle;
        acc(1'b1, 1'b1, 1'b0, 1'b0, t0);
        check("idle_off", n_idle - n0, 0);
        wrr(`XBC_IDX_DRAM_IF, 16'h8800);
        n0 = n_ras;
        n1 = n_oe;
        acc(1'b0, 1'b0, 1'b0, 1'b0, t0);
        check("ras", n_ras > n0, 1);
        check("oe", n_oe > n1, 1);
        check("cke_dram", ext_ctrl.cke, 0);
        // Second access on area 4 so trailing precharge counts once
        acc(1'b1, 1'b1, 1'b0, 1'b0, t1);
        wrr(`XBC_IDX_DRAM_TIMING, 16'h3000);
        acc(1'b0, 1'b0, 1'b0, 1'b0, t2);
        acc(1'b1, 1'b1, 1'b0, 1'b0, t3);
        check("precharge", (t2 + t3) - (t0 + t1), 3);
        wrr(`XBC_IDX_DRAM_TIMING, 16'h0200);
        acc(1'b0, 1'b0, 1'b0, 1'b0, t2);
        check("ras_cas", t2 - t0, 2);
        wrr(`XBC_IDX_DRAM_TIMING, 16'h0000);
        wrr(`XBC_IDX_DRAM_IF, 16'h8880);
        acc(1'b0, 1'b0, 1'b0, 1'b1, t0);
        acc(1'b0, 1'b0, 1'b0, 1'b0, t1);
        wrr(`XBC_IDX_DRAM_IF, 16'h8800);
        acc(1'b0, 1'b0, 1'b0, 1'b1, t2);
        acc(1'b0, 1'b0, 1'b0, 1'b0, t3);
        check("burst", (t0 + t1) < (t2 + t3), 1);
        wrr(`XBC_IDX_DRAM_IF, 16'hc800);
        repeat (2) @(posedge ref_clk);
        check("cke_sdram", ext_ctrl.cke, 1);
        acc(1'b0, 1'b0, 1'b0, 1'b0, t0);
        wrr(`XBC_IDX_AREA2_WAIT, 16'h0100);
        acc(1'b0, 1'b0, 1'b0, 1'b0, t1);
        wrr(`XBC_IDX_AREA2_WAIT, 16'h0500);
        acc(1'b0, 1'b0, 1'b0, 1'b0, t2);
        check("latency", t1 - t0, 1);
        check("latency_top", t2 - t1, 0);
        for (int e = 0; e < 3; e++) begin
            wrr(`XBC_IDX_SYNC_DRAM, (e == 1) ? 16'h8000 : 16'h0000);
            n0 = n_mrs;
            acc(1'b0, 1'b1, 1'b1, 1'b0, t0);
            check("mrs", n_mrs > n0, e == 1);
        end
        // Reset in mid-run while CKE is up and area 2 is DRAM
        rst_n <= 1'b0;
        @(posedge ref_clk);
        check("cke_rst", ext_ctrl.cke, 0);
        check("waitreq_mid", avs_waitrequest, 1);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        bus(1'b0, `XBC_IDX_DRAM_IF, 16'h0);
        check("reset_mid", rd, 0);
        wrr(`XBC_IDX_DRAM_IF, 16'hc000);
        repeat (2) @(posedge ref_clk);
        check("cke_off", ext_ctrl.cke, 0);
        finish_test();
    end
endmodule
`default_nettype wire

// ---- tb/xbc_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module xbc_mem_model #(
    parameter logic [15:0] RD_WORD = 16'h12c4
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire xbc_pkg::xbc_ext_t ext_ctrl,
    input  wire logic              ext_data_oe_n,
    output logic      [15:0]       ext_data_in
);
    import xbc_pkg::*;
    logic        drive;
    logic [15:0] last_q;
    // Bytes differ so a wrong swap shows
    assign drive = (ext_ctrl.cs | ext_ctrl.ras | ext_ctrl.cas) &
                   ~ext_ctrl.wr & ext_data_oe_n;
    // Released bus shows the inverse of the previous cycle's word, so it toggles
    assign ext_data_in = drive ? RD_WORD : ~last_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) last_q <= 16'h0000;
        else last_q <= ext_data_in;
    end
endmodule
`default_nettype wire
